// *** hw/isd_pkg.sv ***
`default_nettype none
package isd_pkg;
  // Request byte fields.
  localparam int REQ_MAGNET_BIT = 0;
  localparam int REQ_FORCE_LSB = 1;
  localparam int REQ_FORCE_MSB = 3;
  localparam int REQ_RESET_BIT = 7;
  // Response byte fields.
  localparam int RSP_OUTPUT_BIT = 0;
  localparam int RSP_ACTUATOR_BIT = 1;
  localparam int RSP_LOCKED_BIT = 2;
  localparam int RSP_INPUTS_BIT = 4;
  localparam int RSP_WARN_BIT = 6;
  localparam int RSP_ERROR_BIT = 7;
  // Diagnostic byte fields.
  localparam int DIAG_OUT_ONE_BIT = 0;
  localparam int DIAG_OUT_TWO_BIT = 1;
  localparam int DIAG_CROSS_BIT = 2;
  localparam int DIAG_TEMP_BIT = 3;
  localparam int DIAG_FOUR_BIT = 4;
  localparam int DIAG_INTERNAL_BIT = 5;
  localparam int DIAG_SIX_BIT = 6;
  localparam int DIAG_UNDERVOLT_BIT = 7;
  // Reset values.
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [2:0] FORCE_RESET = 3'h0;
  // Warning escalation time.
  localparam longint CLK_HZ = 250000000;
  localparam longint WARN_TIMEOUT_MIN = 30;
  localparam longint WARN_TIMEOUT_CYCLES = WARN_TIMEOUT_MIN * 60 * CLK_HZ;
  localparam int TIMER_W = 40;
  // Interlock sequence states.
  typedef enum logic [3:0] {
    ISD_OPEN = 4'h1,
    ISD_CLOSED = 4'h2,
    ISD_LOCKED = 4'h4,
    ISD_FAULT = 4'h8
  } isd_state_e;
endpackage
`default_nettype wire

// *** hw/isd_warn_timer.sv ***
`default_nettype none
// Counts how long a warning has stood and flags expiry; restarts when it clears.
module isd_warn_timer #(
  parameter logic [39:0] LIMIT = 40'(isd_pkg::WARN_TIMEOUT_CYCLES)
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Warning level in, expiry out.
  input wire logic warn_active,
  output logic expired
);
  typedef struct packed {
    logic [isd_pkg::TIMER_W-1:0] count;
    logic expired;
  } isd_timer_s;
  isd_timer_s st_reg;
  isd_timer_s st_next;

  // Count while the warning stands; expiry holds until the warning clears.
  always_comb begin
    st_next = st_reg;
    if (!warn_active) begin
      st_next.count = '0;
      st_next.expired = 1'b0;
    end else if (st_reg.count >= LIMIT - 40'h1) begin
      st_next.expired = 1'b1;
    end else begin
      st_next.count = st_reg.count + 40'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign expired = st_reg.expired;
endmodule // isd_warn_timer
`default_nettype wire

// *** hw/isd_interlock.sv ***
`default_nettype none
// What this block does
// R01 - Gateway request: magnet, force, error reset.
// R02 - Device returns response status byte.
// R03 - All flags active high.
// R04 - Bit0 outputs on while locked, bit4 both inputs.
// R05 - Bit1 actuator detected, bit2 locked.
// R06 - Bit6 warning, bit7 error shutdown.
// R07 - Device returns warning/error diagnostic bytes.
// R08 - Warning byte bits 0 to 5.
// R09 - Warning bit6 gateway communication failure.
// R10 - Error bit4 wrong or defective actuator.
// R11 - Error bit6 forced separation, solenoid variant.
// R12 - Bit7 of diagnostics: undervoltage.
// R13 - Solenoid variant: unlocked keeps outputs off.
// R14 - Locked guard: outputs on, clean status.
// R15 - Actuator variant: outputs on before locking.
// R16 - Lock failure: outputs off, lock clear.
// R17 - Warning keeps outputs; escalates after 30 minutes.
// R18 - Error clears: cause gone plus reset/open.
// R19 - Communication loss freezes switching state.
// R20 - Warning clears itself when cause goes.
// R21 - Gateway serves at most 31 devices.
// R22 - Bytes refreshed continuously; request per exchange.
// R23 - Unassigned bits ignored, driven zero.
module isd_interlock #(
  parameter logic [39:0] WARN_CYCLES = 40'(isd_pkg::WARN_TIMEOUT_CYCLES)
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Variant strap: high for actuator-monitored, low for solenoid-monitored.
  input wire logic actuator_monitored,
  // Request byte from the serial diagnostic line, with its exchange strobe.
  input wire logic [7:0] request_command_byte,
  input wire logic request_valid,
  input wire logic comm_fail,
  // Mechanism sensing.
  input wire logic guard_closed,
  input wire logic actuator_present,
  input wire logic lock_engaged,
  input wire logic safety_input_one,
  input wire logic safety_input_two,
  // Fault causes from the monitoring circuits.
  input wire logic fault_output_one,
  input wire logic fault_output_two,
  input wire logic fault_cross_short,
  input wire logic fault_magnet_temp,
  input wire logic fault_low_force,
  input wire logic fault_bad_actuator,
  input wire logic fault_internal,
  input wire logic fault_separation,
  input wire logic fault_undervoltage,
  // Actuation.
  output logic safety_output_one,
  output logic safety_output_two,
  output logic magnet_on,
  output logic [2:0] latching_force,
  // Status bytes to the serial diagnostic line.
  output logic [7:0] response_status_byte,
  output logic [7:0] diagnostic_warning_byte,
  output logic [7:0] diagnostic_error_byte
);
  typedef struct packed {
    isd_pkg::isd_state_e state;
    logic magnet;
    logic [2:0] force_sel;
    logic reset_prev;
    logic err_latched;
    logic [7:0] err_cause;
    logic outputs_on;
    logic [7:0] rsp;
    logic [7:0] warn;
    logic [7:0] err;
  } isd_state_s;
  isd_state_s st_reg;
  isd_state_s st_next;

  logic warn_expired;
  logic warn_cause;
  logic err_cause_now;
  logic reset_fall;
  logic [7:0] warn_bits;
  logic [7:0] err_bits;
  logic [7:0] rsp_bits;
  logic inputs_ok;

  // The warning timer is the only long count; shorten WARN_CYCLES in simulation.
  isd_warn_timer #(
    .LIMIT(WARN_CYCLES)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .warn_active(warn_cause),
    .expired(warn_expired)
  );

  // R08 warning byte causes
  // Output and wiring faults give a grace period; the rest act at once.
  assign warn_cause = fault_output_one | fault_output_two | fault_cross_short;

  // R17 warning escalates to error
  assign err_cause_now = warn_expired | fault_magnet_temp | fault_low_force | fault_bad_actuator
      | fault_internal | fault_undervoltage | (fault_separation & ~actuator_monitored);

  // R18 reset bit falling edge
  assign reset_fall = request_valid & ~comm_fail & st_reg.reset_prev
      & ~request_command_byte[isd_pkg::REQ_RESET_BIT];

  assign inputs_ok = safety_input_one & safety_input_two;

  // R08 warning byte layout
  // R09 communication failure bit
  // R12 undervoltage flag
  always_comb begin
    warn_bits = isd_pkg::BYTE_RESET;
    warn_bits[isd_pkg::DIAG_OUT_ONE_BIT] = fault_output_one;
    warn_bits[isd_pkg::DIAG_OUT_TWO_BIT] = fault_output_two;
    warn_bits[isd_pkg::DIAG_CROSS_BIT] = fault_cross_short;
    warn_bits[isd_pkg::DIAG_TEMP_BIT] = fault_magnet_temp;
    warn_bits[isd_pkg::DIAG_FOUR_BIT] = fault_low_force;
    warn_bits[isd_pkg::DIAG_INTERNAL_BIT] = fault_internal;
    warn_bits[isd_pkg::DIAG_SIX_BIT] = comm_fail;
    warn_bits[isd_pkg::DIAG_UNDERVOLT_BIT] = fault_undervoltage;
  end

  // R10 error byte layout
  // R11 separation only solenoid variant
  always_comb begin
    err_bits = isd_pkg::BYTE_RESET;
    err_bits[isd_pkg::DIAG_OUT_ONE_BIT] = fault_output_one & warn_expired;
    err_bits[isd_pkg::DIAG_OUT_TWO_BIT] = fault_output_two & warn_expired;
    err_bits[isd_pkg::DIAG_CROSS_BIT] = fault_cross_short & warn_expired;
    err_bits[isd_pkg::DIAG_TEMP_BIT] = fault_magnet_temp;
    err_bits[isd_pkg::DIAG_FOUR_BIT] = fault_bad_actuator;
    err_bits[isd_pkg::DIAG_INTERNAL_BIT] = fault_internal;
    err_bits[isd_pkg::DIAG_SIX_BIT] = fault_separation & ~actuator_monitored;
    err_bits[isd_pkg::DIAG_UNDERVOLT_BIT] = fault_undervoltage;
  end

  // Main sequencing and status assembly.
  always_comb begin
    st_next = st_reg;
    rsp_bits = isd_pkg::BYTE_RESET;

    // R01 request applied per exchange
    // R19 hold on communication loss
    // R22 new request each exchange
    // R23 unassigned request bits ignored
    if (request_valid && !comm_fail) begin
      st_next.magnet = request_command_byte[isd_pkg::REQ_MAGNET_BIT];
      st_next.force_sel = request_command_byte[isd_pkg::REQ_FORCE_MSB:isd_pkg::REQ_FORCE_LSB];
      st_next.reset_prev = request_command_byte[isd_pkg::REQ_RESET_BIT];
    end

    // R18 error latch and clear
    // A new cause wins over a reset in the same cycle, so no fault is lost.
    if (err_cause_now) begin
      st_next.err_latched = 1'b1;
      st_next.err_cause = st_reg.err_cause | err_bits;
    end else if (st_reg.err_latched && (reset_fall || !guard_closed)) begin
      st_next.err_latched = 1'b0;
      st_next.err_cause = isd_pkg::BYTE_RESET;
    end

    // Guard sequence follows the mechanism; faults override everything.
    case (st_reg.state)
      isd_pkg::ISD_OPEN: begin
        if (st_next.err_latched) begin
          st_next.state = isd_pkg::ISD_FAULT;
        end else if (guard_closed && actuator_present) begin
          st_next.state = isd_pkg::ISD_CLOSED;
        end
      end
      isd_pkg::ISD_CLOSED: begin
        if (st_next.err_latched) begin
          st_next.state = isd_pkg::ISD_FAULT;
        end else if (!guard_closed || !actuator_present) begin
          st_next.state = isd_pkg::ISD_OPEN;
        end else if (lock_engaged) begin
          st_next.state = isd_pkg::ISD_LOCKED;
        end
      end
      isd_pkg::ISD_LOCKED: begin
        if (st_next.err_latched) begin
          st_next.state = isd_pkg::ISD_FAULT;
        end else if (!lock_engaged) begin
          st_next.state = guard_closed ? isd_pkg::ISD_CLOSED : isd_pkg::ISD_OPEN;
        end
      end
      isd_pkg::ISD_FAULT: begin
        if (!st_next.err_latched) begin
          st_next.state = isd_pkg::ISD_OPEN;
        end
      end
      default: begin
        st_next.state = isd_pkg::ISD_OPEN;
      end
    endcase

    // R13 solenoid variant unlocked off
    // R14 locked enables outputs
    // R15 actuator variant early enable
    // R16 failed lock keeps outputs off
    // R17 warning keeps outputs enabled
    // Enabling waits for both safety inputs, since the chain upstream must be closed.
    case (st_next.state)
      isd_pkg::ISD_LOCKED: st_next.outputs_on = inputs_ok;
      isd_pkg::ISD_CLOSED: st_next.outputs_on = inputs_ok & actuator_monitored & ~st_next.magnet;
      default: st_next.outputs_on = 1'b0;
    endcase

    // R04 output and inputs bits
    // R05 actuator and lock bits
    // R06 warning and error bits
    // R20 warning self clears
    // R23 unassigned response bits zero
    rsp_bits[isd_pkg::RSP_OUTPUT_BIT] = st_next.outputs_on & (st_next.state == isd_pkg::ISD_LOCKED);
    rsp_bits[isd_pkg::RSP_ACTUATOR_BIT] = (st_next.state == isd_pkg::ISD_LOCKED)
        | ((st_next.state == isd_pkg::ISD_CLOSED)
        & (actuator_monitored | ~(st_next.magnet & ~lock_engaged) | ~actuator_monitored));
    rsp_bits[isd_pkg::RSP_LOCKED_BIT] = (st_next.state == isd_pkg::ISD_LOCKED);
    rsp_bits[isd_pkg::RSP_INPUTS_BIT] = inputs_ok;
    rsp_bits[isd_pkg::RSP_WARN_BIT] = warn_cause & ~st_next.err_latched;
    rsp_bits[isd_pkg::RSP_ERROR_BIT] = st_next.err_latched;
    // A failed lock in the actuator variant drops the actuator bit too.
    if (actuator_monitored && st_next.magnet && !lock_engaged
        && st_next.state == isd_pkg::ISD_CLOSED) begin
      rsp_bits[isd_pkg::RSP_ACTUATOR_BIT] = 1'b0;
    end

    // R02 response byte refreshed
    // R03 active-high flags
    // R07 diagnostic bytes sent
    // R22 continuous refresh
    st_next.rsp = rsp_bits;
    st_next.warn = warn_bits;
    st_next.err = st_next.err_latched ? (st_next.err_cause | err_bits) : isd_pkg::BYTE_RESET;
  end

  // State register.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg.state <= isd_pkg::ISD_OPEN;
      st_reg.magnet <= 1'b0;
      st_reg.force_sel <= isd_pkg::FORCE_RESET;
      st_reg.reset_prev <= 1'b0;
      st_reg.err_latched <= 1'b0;
      st_reg.err_cause <= isd_pkg::BYTE_RESET;
      st_reg.outputs_on <= 1'b0;
      st_reg.rsp <= isd_pkg::BYTE_RESET;
      st_reg.warn <= isd_pkg::BYTE_RESET;
      st_reg.err <= isd_pkg::BYTE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // All outputs come straight from the state register.
  assign safety_output_one = st_reg.outputs_on;
  assign safety_output_two = st_reg.outputs_on;
  assign magnet_on = st_reg.magnet;
  assign latching_force = st_reg.force_sel;
  assign response_status_byte = st_reg.rsp;
  assign diagnostic_warning_byte = st_reg.warn;
  assign diagnostic_error_byte = st_reg.err;
endmodule // isd_interlock
`default_nettype wire

// *** verif/isd_gateway_model.sv ***
`default_nettype none
// Gateway stand-in: one strobe per request byte, link fault held as a level.
module isd_gateway_model (
  // Clock.
  input wire logic clk,
  // Request side of the diagnostic line.
  output logic [7:0] request_command_byte,
  output logic request_valid,
  output logic comm_fail
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle line and healthy link at start.
  initial begin
    request_command_byte = 8'h00;
    request_valid = 1'b0;
    comm_fail = 1'b0;
  end
  // one device, one exchange.
  // The byte is inverted once released so a stale value is never mistaken for a request.
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    #1 request_valid = 1'b1;
    request_command_byte = b;
    @(posedge clk);
    #1 request_valid = 1'b0;
    request_command_byte = ~b;
  endtask
  // Link fault changes just after an edge.
  task automatic link(input logic f);
    @(posedge clk);
    #1 comm_fail = f;
  endtask
endmodule // isd_gateway_model
`default_nettype wire

// *** verif/isd_interlock_monitor.sv ***
`default_nettype none
// Port checks; every status output lags its cause by one edge.
module isd_interlock_monitor #(
  parameter logic [39:0] WARN_CYCLES = 40'h10
) (
  // Clock, reset and strap.
  input wire logic clk, rst_n, actuator_monitored,
  // Request side.
  input wire logic [7:0] request_command_byte,
  input wire logic request_valid, comm_fail,
  // Sensing and fault causes.
  input wire logic safety_input_one, safety_input_two, fault_output_one, fault_output_two,
  input wire logic fault_cross_short, fault_magnet_temp, fault_low_force, fault_internal,
  input wire logic fault_undervoltage,
  // Outputs under watch.
  input wire logic safety_output_one, safety_output_two, magnet_on,
  input wire logic [2:0] latching_force,
  input wire logic [7:0] response_status_byte, diagnostic_warning_byte
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_req_copy:
  assert property (request_valid && !comm_fail |=> magnet_on == $past(request_command_byte[0])
    && latching_force == $past(request_command_byte[3:1])) else $error("request not applied");
  chk_link_hold:
  assert property (comm_fail |=> $stable(magnet_on) && $stable(latching_force))
    else $error("request taken during link fault");
  chk_spare_zero:
  assert property (response_status_byte[3] == 1'b0 && response_status_byte[5] == 1'b0)
    else $error("spare response bit set");
  chk_input_bit:
  assert property ($past(rst_n) |->
    response_status_byte[4] == $past(safety_input_one && safety_input_two))
    else $error("input bit wrong");
  chk_warn_live:
  assert property ($past(rst_n) |-> diagnostic_warning_byte == $past({fault_undervoltage,
    comm_fail, fault_internal, fault_low_force, fault_magnet_temp, fault_cross_short,
    fault_output_two, fault_output_one})) else $error("warning byte wrong");
  chk_err_off:
  assert property (response_status_byte[7] [*2] |-> !safety_output_one && !safety_output_two)
    else $error("outputs on during error");
  chk_out_lock:
  assert property (response_status_byte[0] |-> response_status_byte[2] && safety_output_one)
    else $error("output bit without lock");
  chk_out_inputs:
  assert property (safety_output_one || safety_output_two |-> safety_output_one ==
    safety_output_two && $past(safety_input_one && safety_input_two))
    else $error("outputs split or inputs low");
  chk_solenoid_lock:
  assert property (!actuator_monitored && safety_output_one |-> response_status_byte[2])
    else $error("outputs on unlocked");
endmodule // isd_interlock_monitor
bind isd_interlock isd_interlock_monitor #(.WARN_CYCLES(WARN_CYCLES)) isd_interlock_monitor_i (.*);
`default_nettype wire

// *** verif/isd_interlock_tb.sv ***
`default_nettype none
module isd_interlock_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic var_a = 1'b0;
  logic [4:0] mech = 5'h00; // Guard, actuator, lock, input one, input two.
  logic [8:0] flt = 9'h000;
  logic [7:0] req, rsp, warn, err;
  logic req_v, link_bad, so1, so2, mag;
  logic [2:0] force_q;
  logic [51:0] q[$];
  logic [51:0] n;
  int n_mismatch = 0;
  int samples_checked = 0;
  // Immediate error causes: temperature, low force, bad actuator, internal, separation, voltage.
  int fi[6] = '{3, 4, 5, 6, 7, 8};
  logic [7:0] wb[6] = '{8'h08, 8'h10, 8'h00, 8'h20, 8'h00, 8'h80};
  logic [7:0] eb[6] = '{8'h08, 8'h00, 8'h10, 8'h20, 8'h40, 8'h80};
  event note;
  localparam logic [25:0] ALL = 26'h3ffffff;
  localparam logic [25:0] ERR_M = 26'h3f9ffff; // Lock and actuator bits are free in error.
  localparam logic [25:0] CLR_M = 26'h0f8ffff; // Relock after a clear is not timed here.
  // Free-running clock.
  always #2 clk = ~clk;
  isd_gateway_model isd_gateway_model_i (.clk(clk), .request_command_byte(req),
    .request_valid(req_v), .comm_fail(link_bad));
  isd_interlock #(.WARN_CYCLES(40'h10)) isd_interlock_i (.clk(clk), .rst_n(rst_n),
    .actuator_monitored(var_a), .request_command_byte(req), .request_valid(req_v),
    .comm_fail(link_bad), .guard_closed(mech[4]), .actuator_present(mech[3]),
    .lock_engaged(mech[2]), .safety_input_one(mech[1]), .safety_input_two(mech[0]),
    .fault_output_one(flt[0]), .fault_output_two(flt[1]), .fault_cross_short(flt[2]),
    .fault_magnet_temp(flt[3]), .fault_low_force(flt[4]), .fault_bad_actuator(flt[5]),
    .fault_internal(flt[6]), .fault_separation(flt[7]), .fault_undervoltage(flt[8]),
    .safety_output_one(so1), .safety_output_two(so2), .magnet_on(mag),
    .latching_force(force_q), .response_status_byte(rsp),
    .diagnostic_warning_byte(warn), .diagnostic_error_byte(err));
  // Scoreboard: the oldest note against the settled outputs, masked bits ignored.
  always @(note) begin
    n = q.pop_front();
    samples_checked++;
    if ((({so1, so2, rsp, warn, err} ^ n[51:26]) & n[25:0]) !== 26'h0) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, {so1, so2, rsp, warn, err}, n[51:26]);
    end
  end
  // Lets registered outputs settle, then files the expectation.
  task automatic settle(input logic [25:0] e, input logic [25:0] m);
    repeat (3) @(posedge clk);
    #1 q.push_back({e, m});
    -> note;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Main sequence; the solenoid-monitored variant comes first.
  initial begin
    void'($urandom(3));
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    isd_gateway_model_i.send(8'h01);
    settle(26'h0, ALL);
    mech = 5'h1b;
    settle({2'b00, 8'h12, 16'h0}, ALL);
    repeat (4) isd_gateway_model_i.send(8'h01 | 8'($urandom() & 32'h7e));
    mech = 5'h1f;
    settle({2'b11, 8'h17, 16'h0}, ALL);
    flt[0] = 1'b1;
    settle({2'b11, 8'h57, 8'h01, 8'h00}, ALL);
    repeat (30) @(posedge clk);
    settle({2'b00, 8'h96, 8'h01, 8'h01}, ERR_M);
    flt = 9'h000;
    mech = 5'h03;
    settle({2'b00, 8'h10, 16'h0}, ALL);
    mech = 5'h1f;
    flt[2:1] = 2'b11;
    settle({2'b11, 8'h57, 8'h06, 8'h00}, ALL);
    flt = 9'h000;
    settle({2'b11, 8'h17, 16'h0}, ALL);
    for (int i = 0; i < 6; i++) begin
      flt[fi[i]] = 1'b1;
      settle({2'b00, 8'h90, wb[i], eb[i]}, ERR_M);
      flt = 9'h000;
      isd_gateway_model_i.send(8'h81);
      isd_gateway_model_i.send(8'h01);
      settle({2'b00, 8'h10, 16'h0}, CLR_M);
    end
    isd_gateway_model_i.link(1'b1);
    isd_gateway_model_i.send(8'h0e);
    settle({18'h0, 8'h40, 8'h00}, 26'h000ffff);
    isd_gateway_model_i.link(1'b0);
    mech = 5'h00;
    isd_gateway_model_i.send(8'h00);
    var_a = 1'b1;
    mech = 5'h1b;
    settle({2'b11, 8'h12, 16'h0}, ALL);
    isd_gateway_model_i.send(8'h01);
    settle({2'b00, 8'h10, 16'h0}, ALL);
    finish_test();
  end
  // Watchdog at about sixteen times the expected run.
  initial begin
    #10000;
    n_mismatch++;
    finish_test();
  end
endmodule // isd_interlock_tb
`default_nettype wire
